//--- hw/eep_mem.sv
`timescale 1ns/1ps
`default_nettype none
module eep_mem
  import eep_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic re,
  input wire logic [MEM_AW-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic [DATA_W-1:0] rdata_q;

  // Array left unreset: contents model nonvolatile cells
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RST_BYTE;
    end else if (re) begin
      rdata_q <= mem_q[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule
`default_nettype wire

//--- hw/eep_pkg.sv
package eep_pkg;

  localparam int CLK_PERIOD_NS = 100;
  // Power-up timer and self-timed write durations
  localparam int PWRT_TIME_MS = 64;
  localparam int WRITE_TIME_MS = 4;
  localparam int PWRT_CYCLES_DEF = (PWRT_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES_DEF = (WRITE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRT_CNT_W = 24;
  localparam int WRITE_CNT_W = 16;

  localparam int DATA_W = 8;
  localparam int BUS_AW = 4;
  localparam int EXT_AW = 16;
  localparam int MEM_AW = 10;
  localparam int MEM_DEPTH = 1024;

  localparam logic [3:0] OFF_INTCTL = 4'h0;
  localparam logic [3:0] OFF_ADDR_HI = 4'h1;
  localparam logic [3:0] OFF_ADDR_LO = 4'h2;
  localparam logic [3:0] OFF_DATA = 4'h3;
  localparam logic [3:0] OFF_UNLOCK = 4'h4;
  localparam logic [3:0] OFF_CTRL = 4'h5;
  localparam logic [3:0] OFF_PRIO6 = 4'h6;
  localparam logic [3:0] OFF_FLAGS6 = 4'h7;
  localparam logic [3:0] OFF_EN6 = 4'h8;
  localparam logic [3:0] OFF_IRQ_ST = 4'h9;
  localparam logic [3:0] OFF_IRQ_MASK = 4'hA;

  localparam int CTRL_PGD = 7;
  localparam int CTRL_CONFIG_SPACE_SELECT = 6;
  localparam int CTRL_FREE = 4;
  localparam int CTRL_WERR = 3;
  localparam int CTRL_WRITE_ENABLE_LATCH = 2;
  localparam int CTRL_WR = 1;
  localparam int CTRL_RD = 0;
  localparam int PERIPH_EE_BIT = 4;
  localparam int INTCTL_GIE = 7;

  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WBAD = 1;
  localparam int IRQ_EXTREF = 2;

  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'h0,
    UNL_GOT55 = 2'h1,
    UNL_ARMED = 2'h3
  } eep_unlock_type;

  typedef struct packed {
    logic we;
    logic re;
    logic [BUS_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } eep_bus_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [EXT_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } eep_ext_type;

endpackage

//--- hw/eep_top.sv
// Notes on behaviour
// [RULE_01] Code protect refuses external reads and writes
// [RULE_02] CPU path works regardless of protection
// [RULE_03] Power-up clears the write enable latch
// [RULE_04] No writes while power-up timer runs
// [RULE_05] Write needs enable latch plus unlock
// [RULE_06] Byte access via address pair, data byte
// [RULE_07] Unlock port stores nothing, reads zero
// [RULE_08] Unimplemented register bits read as zero
// [RULE_09] Done flag, enable, priority at bit 4
// [RULE_10] Unlock order 0x55, 0xAA, then write bit
// [RULE_11] Completion clears write bit, sets flag
// [RULE_12] Read bit loads data, then self-clears
// [RULE_13] Registers locked during write; latch first
// [RULE_14] Broken order returns unlock detector to idle
`timescale 1ns/1ps
`default_nettype none
module eep_top
  import eep_pkg::*;
#(
  parameter int PWRT_CYCLES = PWRT_CYCLES_DEF,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire eep_bus_type bus,
  output logic [DATA_W-1:0] rdata,
  input wire logic cp_data_on,
  input wire eep_ext_type ext,
  output logic [DATA_W-1:0] ext_rdata,
  output logic ext_ack,
  output logic ext_refused,
  output logic irq,
  output logic ee_irq_req,
  output logic ee_irq_high,
  output logic global_irq_enable
);

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_q[1];

  function automatic logic hit(input logic strobe, input logic [BUS_AW-1:0] a, input logic [BUS_AW-1:0] off);
    hit = strobe && (a == off);
  endfunction

  logic [DATA_W-1:0] intctl_q, addr_hi_q, addr_lo_q, data_q, rdata_q;
  logic pgd_q, config_space_select_q, free_q, werr_q, write_enable_latch_q, wr_q, rd_q;
  logic prio_q, flag_q, en_q;
  logic [IRQ_W-1:0] irq_st_q, irq_mask_q, irq_set;
  logic busy_q, src_ext_q, ext_rd_q, ext_ref_q;
  logic [WRITE_CNT_W-1:0] wcnt_q;
  logic [PWRT_CNT_W-1:0] pwrt_q;
  logic [MEM_AW-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  eep_unlock_type unl_q, unl_d;

  wire w_intctl = hit(bus.we, bus.addr, OFF_INTCTL);
  wire w_addr_hi = hit(bus.we, bus.addr, OFF_ADDR_HI);
  wire w_addr_lo = hit(bus.we, bus.addr, OFF_ADDR_LO);
  wire w_data = hit(bus.we, bus.addr, OFF_DATA);
  wire w_unlock = hit(bus.we, bus.addr, OFF_UNLOCK);
  wire w_ctrl = hit(bus.we, bus.addr, OFF_CTRL);
  wire w_prio = hit(bus.we, bus.addr, OFF_PRIO6);
  wire w_flags = hit(bus.we, bus.addr, OFF_FLAGS6);
  wire w_en = hit(bus.we, bus.addr, OFF_EN6);
  wire w_mask = hit(bus.we, bus.addr, OFF_IRQ_MASK);
  wire r_irq_st = hit(bus.re, bus.addr, OFF_IRQ_ST);
  wire bus_acc = bus.we || bus.re;

  // Locks cover the whole self-timed cycle, whichever path started it
  wire lock = busy_q; // RULE_13
  wire pwrt_active = (pwrt_q != PWRT_CNT_W'(PWRT_CYCLES));
  wire data_sel = !bus.wdata[CTRL_PGD] && !bus.wdata[CTRL_CONFIG_SPACE_SELECT];
  wire wr_try = w_ctrl && bus.wdata[CTRL_WR] && !busy_q;
  // Old latch value: latch and write bit in one access never starts
  wire cpu_start = wr_try && (unl_q == UNL_ARMED) && write_enable_latch_q && !pwrt_active && data_sel; // RULE_05 RULE_04 RULE_13
  wire wr_bad = wr_try && !cpu_start;
  wire rd_set = w_ctrl && bus.wdata[CTRL_RD] && !lock && data_sel && !rd_q; // RULE_02 RULE_12
  wire [2*DATA_W-1:0] addr_pair = {addr_hi_q, addr_lo_q};
  wire [MEM_AW-1:0] cpu_addr = addr_pair[MEM_AW-1:0]; // RULE_06

  wire ext_any = ext.rd || ext.wr;
  wire ext_wr_ok = ext.wr && !cp_data_on && !busy_q && !pwrt_active && !cpu_start; // RULE_01 RULE_04
  wire ext_rd_ok = ext.rd && !ext.wr && !cp_data_on && !rd_set; // RULE_01
  wire ext_ref = ext_any && !ext_wr_ok && !ext_rd_ok;
  wire start = cpu_start || ext_wr_ok;
  wire done = busy_q && (wcnt_q == WRITE_CNT_W'(WRITE_CYCLES - 1));
  wire cpu_done = done && !src_ext_q;

  wire mem_re = rd_set || ext_rd_ok;
  wire [MEM_AW-1:0] mem_raddr = rd_set ? cpu_addr : ext.addr[MEM_AW-1:0];
  wire [DATA_W-1:0] mem_rdata;

  eep_mem u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .we(done),
    .waddr(waddr_q),
    .wdata(wdata_q),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrt_q <= '0;
    end else if (pwrt_active) begin
      pwrt_q <= pwrt_q + 1'h1;
    end
  end

  always_comb begin
    unl_d = unl_q;
    unique case (unl_q)
      UNL_IDLE: begin
        if (w_unlock && bus.wdata == UNLOCK_KEY1) begin
          unl_d = UNL_GOT55;
        end
      end
      UNL_GOT55: begin
        if (w_unlock && bus.wdata == UNLOCK_KEY2) begin
          unl_d = UNL_ARMED; // RULE_10
        end else if (w_unlock && bus.wdata == UNLOCK_KEY1) begin
          unl_d = UNL_GOT55;
        end else if (bus_acc) begin
          unl_d = UNL_IDLE; // RULE_14
        end
      end
      UNL_ARMED: begin
        if (bus_acc) begin
          unl_d = UNL_IDLE; // RULE_14
        end
      end
      default: unl_d = UNL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unl_q <= UNL_IDLE;
    end else begin
      unl_q <= unl_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'h0;
      src_ext_q <= 1'h0;
      wcnt_q <= '0;
      waddr_q <= '0;
      wdata_q <= RST_BYTE;
    end else if (start) begin
      busy_q <= 1'h1;
      src_ext_q <= ext_wr_ok;
      wcnt_q <= '0;
      waddr_q <= ext_wr_ok ? ext.addr[MEM_AW-1:0] : cpu_addr;
      wdata_q <= ext_wr_ok ? ext.data : data_q;
    end else if (busy_q) begin
      busy_q <= !done;
      wcnt_q <= wcnt_q + 1'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hi_q <= RST_BYTE;
      addr_lo_q <= RST_BYTE;
      data_q <= RST_BYTE;
      intctl_q <= RST_BYTE;
    end else begin
      intctl_q <= w_intctl ? bus.wdata : intctl_q;
      addr_hi_q <= (w_addr_hi && !lock) ? bus.wdata : addr_hi_q; // RULE_13
      addr_lo_q <= (w_addr_lo && !lock) ? bus.wdata : addr_lo_q; // RULE_13
      if (rd_q) begin
        data_q <= mem_rdata; // RULE_12
      end else if (w_data && !lock) begin
        data_q <= bus.wdata; // RULE_13
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pgd_q, config_space_select_q, free_q, werr_q} <= 4'h0;
      write_enable_latch_q <= 1'h0; // RULE_03
      wr_q <= 1'h0;
      rd_q <= 1'h0;
    end else begin
      if (w_ctrl && !lock) begin
        pgd_q <= bus.wdata[CTRL_PGD];
        config_space_select_q <= bus.wdata[CTRL_CONFIG_SPACE_SELECT];
        free_q <= bus.wdata[CTRL_FREE];
        write_enable_latch_q <= bus.wdata[CTRL_WRITE_ENABLE_LATCH];
      end
      // Improper attempt sets the error bit even against a clear
      if (wr_bad) begin
        werr_q <= 1'h1;
      end else if (w_ctrl && !lock) begin
        werr_q <= bus.wdata[CTRL_WERR];
      end
      wr_q <= cpu_start || (wr_q && !done); // RULE_11
      rd_q <= rd_set; // RULE_12
    end
  end

  assign irq_set = {ext_ref, wr_bad, cpu_done};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_q <= 1'h0;
      en_q <= 1'h0;
      flag_q <= 1'h0;
      irq_st_q <= '0;
      irq_mask_q <= '0;
    end else begin
      prio_q <= w_prio ? bus.wdata[PERIPH_EE_BIT] : prio_q; // RULE_09
      en_q <= w_en ? bus.wdata[PERIPH_EE_BIT] : en_q; // RULE_09
      flag_q <= cpu_done || (w_flags ? bus.wdata[PERIPH_EE_BIT] : flag_q); // RULE_11 RULE_09
      irq_mask_q <= w_mask ? bus.wdata[IRQ_W-1:0] : irq_mask_q;
      irq_st_q <= irq_set | (r_irq_st ? '0 : irq_st_q);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_rd_q <= 1'h0;
      ext_ref_q <= 1'h0;
    end else begin
      ext_rd_q <= ext_rd_ok;
      ext_ref_q <= ext_ref; // RULE_01
    end
  end

  wire [DATA_W-1:0] ctrl_rd = {pgd_q, config_space_select_q, 1'h0, free_q, werr_q, write_enable_latch_q, wr_q, rd_q}; // RULE_08
  wire [DATA_W-1:0] ee_bit4 = 8'h10;
  // Unlock port and unmapped offsets fall through to zero
  wire [DATA_W-1:0] rd_mux =
    (bus.addr == OFF_INTCTL) ? intctl_q :
    (bus.addr == OFF_ADDR_HI) ? addr_hi_q :
    (bus.addr == OFF_ADDR_LO) ? addr_lo_q :
    (bus.addr == OFF_DATA) ? data_q :
    (bus.addr == OFF_CTRL) ? ctrl_rd :
    (bus.addr == OFF_PRIO6) ? (prio_q ? ee_bit4 : RST_BYTE) : // RULE_08
    (bus.addr == OFF_FLAGS6) ? (flag_q ? ee_bit4 : RST_BYTE) :
    (bus.addr == OFF_EN6) ? (en_q ? ee_bit4 : RST_BYTE) :
    (bus.addr == OFF_IRQ_ST) ? {{(DATA_W-IRQ_W){1'h0}}, irq_st_q} :
    (bus.addr == OFF_IRQ_MASK) ? {{(DATA_W-IRQ_W){1'h0}}, irq_mask_q} :
    RST_BYTE; // RULE_07

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RST_BYTE;
    end else begin
      rdata_q <= bus.re ? rd_mux : RST_BYTE;
    end
  end

  assign rdata = rdata_q;
  assign ext_rdata = mem_rdata;
  assign ext_ack = ext_rd_q || (done && src_ext_q);
  assign ext_refused = ext_ref_q;
  assign irq = |(irq_st_q & irq_mask_q);
  assign ee_irq_req = flag_q && en_q;
  assign ee_irq_high = flag_q && en_q && prio_q;
  assign global_irq_enable = intctl_q[INTCTL_GIE];

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_key1;
    w_unlock && bus.wdata == UNLOCK_KEY1 && unl_q == UNL_IDLE;
  endsequence

  sequence s_key2;
    w_unlock && bus.wdata == UNLOCK_KEY2;
  endsequence

  a_ext_cp_refuse: assert property (ext_any && cp_data_on |-> !start ##1 ext_refused) // RULE_01
    else $error("external access taken under code protect");
  a_cpu_read_cp: assert property (w_ctrl && bus.wdata == 8'h01 && !lock && !rd_q |=> rd_q ##1 !rd_q) // RULE_02
    else $error("cpu read not started or read bit stuck");
  a_rd_loads: assert property (rd_q |=> data_q == $past(mem_rdata) && !rd_q) // RULE_12
    else $error("read data not loaded into data byte");
  a_pwrt_block: assert property (pwrt_active |-> !start && !busy_q) // RULE_04
    else $error("write started during power-up timer");
  a_start_needs_key: assert property (cpu_start |-> $past(write_enable_latch_q) && unl_q == UNL_ARMED) // RULE_05
    else $error("write started without latch and unlock");
  a_unlock_order: assert property (s_key1 ##1 s_key2 |=> unl_q == UNL_ARMED) // RULE_10
    else $error("unlock sequence not armed");
  a_break_idle: assert property (unl_q == UNL_GOT55 && bus.re |=> unl_q == UNL_IDLE) // RULE_14
    else $error("unlock detector kept state after broken order");
  a_lock_regs: assert property (busy_q && (w_addr_lo || w_data) |=> $stable(addr_lo_q) && $stable(data_q)) // RULE_13
    else $error("register changed during write cycle");
  a_done_flag: assert property (cpu_done |=> flag_q && !wr_q && !busy_q) // RULE_11
    else $error("completion did not set flag or clear write bit");
  a_unlock_zero: assert property (hit(bus.re, bus.addr, OFF_UNLOCK) |=> rdata == RST_BYTE) // RULE_07
    else $error("unlock port read not zero");
  a_unused_zero: assert property (hit(bus.re, bus.addr, OFF_FLAGS6) |=> (rdata & 8'hEF) == RST_BYTE) // RULE_08
    else $error("unimplemented flag bits read nonzero");
  a_write_enable_latch_cleared: assert property (pwrt_q == '0 |-> !write_enable_latch_q) // RULE_03
    else $error("write enable latch set at power-up");

endmodule
`default_nettype wire

//--- tb/eep_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module eep_prog_model
  import eep_pkg::*;
(
  input wire logic core_clk,
  output var eep_ext_type ext,
  input wire logic [DATA_W-1:0] ext_rdata,
  input wire logic ext_ack,
  input wire logic ext_refused
);
  initial begin
    ext = '0;
  end

  // One request pulse, then lines turn over so stale values never look valid
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic ack, output logic refd, output logic [7:0] q);
    int i;
    ack = 1'b0;
    refd = 1'b0;
    q = 8'h00;
    @(posedge core_clk);
    ext <= '{rd: !wr, wr: wr, addr: a, data: d};
    @(posedge core_clk);
    ext <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
    for (i = 0; i < 30; i++) begin
      @(negedge core_clk);
      if (ext_ack === 1'b1 || ext_refused === 1'b1) begin
        ack = ext_ack;
        refd = ext_refused;
        q = ext_rdata;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import eep_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cp_data_on = 1'b0;
  eep_bus_type bus = '0;
  eep_ext_type ext;
  logic [7:0] rdata, ext_rdata, q;
  logic ext_ack, ext_refused, irq, ee_irq_req, ee_irq_high, global_irq_enable, a, r;
  int bad_count = 0;
  int checked = 0;

  eep_top #(.PWRT_CYCLES(20), .WRITE_CYCLES(8)) uut (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .rdata(rdata), .cp_data_on(cp_data_on), .ext(ext), .ext_rdata(ext_rdata), .ext_ack(ext_ack),
    .ext_refused(ext_refused), .irq(irq), .ee_irq_req(ee_irq_req), .ee_irq_high(ee_irq_high),
    .global_irq_enable(global_irq_enable));
  eep_prog_model prog (.core_clk(core_clk), .ext(ext), .ext_rdata(ext_rdata), .ext_ack(ext_ack),
    .ext_refused(ext_refused));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  task wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{we: 1'b1, re: 1'b0, addr: ad, wdata: d};
    @(posedge core_clk);
    bus <= '0;
  endtask

  task rd(input logic [3:0] ad, output logic [7:0] v);
    @(posedge core_clk);
    bus <= '{we: 1'b0, re: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge core_clk);
    bus <= '0;
    @(negedge core_clk);
    v = rdata;
  endtask

  task unlock();
    wr(OFF_UNLOCK, UNLOCK_KEY1);
    wr(OFF_UNLOCK, UNLOCK_KEY2);
  endtask

  task t_pwrt();
    prog.xfer(1'b1, 16'h0010, 8'h99, a, r, q);
    chk({7'h0, r}, 8'h01, "ext wr in pwrt");
    rd(OFF_CTRL, q);
    chk(q & 8'h3F, 8'h00, "ctrl after reset");
    wr(OFF_CTRL, 8'h04);
    unlock();
    wr(OFF_CTRL, 8'h06);
    rd(OFF_CTRL, q);
    chk(q & 8'h0A, 8'h08, "cpu wr in pwrt");
    repeat (20) @(posedge core_clk);
    rd(OFF_IRQ_ST, q);
    chk(q, 8'h06, "pwrt status");
    $display("test pwrt done");
  endtask

  task t_regs();
    wr(OFF_UNLOCK, 8'h5A);
    rd(OFF_UNLOCK, q);
    chk(q, 8'h00, "unlock port");
    wr(OFF_PRIO6, 8'hFF);
    rd(OFF_PRIO6, q);
    chk(q, 8'h10, "prio6");
    wr(OFF_EN6, 8'hFF);
    rd(OFF_EN6, q);
    chk(q, 8'h10, "en6");
    wr(4'hB, 8'hFF);
    rd(4'hB, q);
    chk(q, 8'h00, "unmapped");
    wr(OFF_IRQ_MASK, 8'hFF);
    rd(OFF_IRQ_MASK, q);
    chk(q, 8'h07, "irq mask");
    wr(OFF_INTCTL, 8'h80);
    @(negedge core_clk);
    chk({7'h0, global_irq_enable}, 8'h01, "gie");
    $display("test regs done");
  endtask

  task t_write();
    int i;
    wr(OFF_ADDR_HI, 8'h02);
    wr(OFF_ADDR_LO, 8'h5A);
    wr(OFF_DATA, 8'hC3);
    wr(OFF_CTRL, 8'h04);
    unlock();
    wr(OFF_CTRL, 8'h06);
    rd(OFF_CTRL, q);
    chk(q & 8'h0F, 8'h06, "busy");
    // Locked registers must keep the values of the running write
    wr(OFF_DATA, 8'h11);
    wr(OFF_ADDR_LO, 8'h00);
    rd(OFF_ADDR_LO, q);
    chk(q, 8'h5A, "addr locked");
    for (i = 0; i < 20; i++) begin
      rd(OFF_CTRL, q);
      if (q[1] === 1'b0) break;
    end
    chk(q & 8'h02, 8'h00, "wr bit clear");
    rd(OFF_FLAGS6, q);
    chk(q, 8'h10, "done flag");
    chk({6'h0, ee_irq_high, ee_irq_req}, 8'h03, "ee irq");
    chk({7'h0, irq}, 8'h01, "irq up");
    rd(OFF_IRQ_ST, q);
    chk(q, 8'h01, "irq status");
    chk({7'h0, irq}, 8'h00, "irq down");
    wr(OFF_FLAGS6, 8'h00);
    rd(OFF_FLAGS6, q);
    chk(q, 8'h00, "flag clear");
    wr(OFF_DATA, 8'h00);
    wr(OFF_CTRL, 8'h05);
    rd(OFF_DATA, q);
    chk(q, 8'hC3, "read back");
    rd(OFF_CTRL, q);
    chk(q & 8'h01, 8'h00, "rd bit clear");
    $display("test write done");
  endtask

  task t_bad();
    int k;
    for (k = 0; k < 3; k++) begin
      wr(OFF_CTRL, (k == 2) ? 8'h00 : 8'h04);
      wr(OFF_DATA, 8'h77);
      case (k)
        0: begin
          wr(OFF_UNLOCK, UNLOCK_KEY1);
          rd(OFF_ADDR_LO, q);
          wr(OFF_UNLOCK, UNLOCK_KEY2);
        end
        1: begin
          wr(OFF_UNLOCK, UNLOCK_KEY2);
          wr(OFF_UNLOCK, UNLOCK_KEY1);
        end
        default: unlock();
      endcase
      wr(OFF_CTRL, 8'h06);
      rd(OFF_CTRL, q);
      chk(q & 8'h0A, 8'h08, "refused start");
      rd(OFF_IRQ_ST, q);
      chk(q, 8'h02, "improper status");
    end
    wr(OFF_CTRL, 8'h01);
    rd(OFF_DATA, q);
    chk(q, 8'hC3, "mem unchanged");
    // Read bit must not fire with program memory selected
    wr(OFF_DATA, 8'h5A);
    wr(OFF_CTRL, 8'h81);
    rd(OFF_DATA, q);
    chk(q, 8'h5A, "rd refused pgd");
    rd(OFF_CTRL, q);
    chk(q & 8'h81, 8'h80, "pgd rd bit");
    $display("test bad done");
  endtask

  task t_ext();
    @(posedge core_clk);
    cp_data_on <= 1'b1;
    prog.xfer(1'b0, 16'h025A, 8'h00, a, r, q);
    chk({6'h0, a, r}, 8'h01, "ext rd protected");
    prog.xfer(1'b1, 16'h025A, 8'h3C, a, r, q);
    chk({6'h0, a, r}, 8'h01, "ext wr protected");
    chk({7'h0, irq}, 8'h01, "irq refused");
    rd(OFF_IRQ_ST, q);
    chk(q, 8'h04, "refused status");
    wr(OFF_DATA, 8'h00);
    wr(OFF_CTRL, 8'h01);
    rd(OFF_DATA, q);
    chk(q, 8'hC3, "cpu rd protected");
    @(posedge core_clk);
    cp_data_on <= 1'b0;
    prog.xfer(1'b1, 16'h025A, 8'h3C, a, r, q);
    chk({6'h0, a, r}, 8'h02, "ext wr ok");
    prog.xfer(1'b0, 16'h025A, 8'h00, a, r, q);
    chk(q, 8'h3C, "ext rd ok");
    $display("test ext done");
  endtask

  task summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_pwrt();
    t_regs();
    t_write();
    t_bad();
    t_ext();
    summarize();
  end
endmodule
`default_nettype wire
